// file: src/pdst_defines.svh
`ifndef PDST_DEFINES_SVH
`define PDST_DEFINES_SVH

// Page register reset value
`define PDST_PAGE_RESET 10'h001
// Page value from which reads go to program space
`define PDST_PSV_FIRST_PAGE 10'h200
// Page value that may never be used through the upper window
`define PDST_PAGE_ZERO 10'h000
// Bits each page register keeps
`define PDST_RD_PAGE_MASK 10'h3ff
`define PDST_WR_PAGE_MASK 10'h1ff
// Last address of the always-visible low region
`define PDST_LOW_LAST 16'h2fff
// Position of the base address msb
`define PDST_BASE_MSB 15

`endif

// file: src/pdst_pkg.sv
package pdst_pkg;

  typedef enum logic [1:0] {
    PDST_SP_BASE,
    PDST_SP_EDS,
    PDST_SP_PSV,
    PDST_SP_NONE
  } pdst_space_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
  } pdst_req_t;

  typedef struct packed {
    logic valid;
    logic sel_write;
    logic [9:0] value;
  } pdst_page_wr_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic low_region;
    pdst_space_t space;
    logic [23:0] addr;
  } pdst_resp_t;

endpackage

// file: src/pdst_page_reg.sv
`timescale 1ns/1ps
`include "pdst_defines.svh"

module pdst_page_reg #(
  parameter logic [9:0] KEEP_MASK = `PDST_RD_PAGE_MASK
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic [9:0] data_i,
  output logic [9:0] q_o
);

  logic [9:0] masked;

  assign masked = data_i & KEEP_MASK;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= `PDST_PAGE_RESET;
    end else if (wr_i && (masked != `PDST_PAGE_ZERO)) begin
      q_o <= masked;
    end
  end

endmodule

// file: src/pdst_translator.sv
`timescale 1ns/1ps
`include "pdst_defines.svh"

module pdst_translator (
  input wire logic clk_i,
  input wire logic nrst_i,
  input pdst_pkg::pdst_req_t req_i,
  input pdst_pkg::pdst_page_wr_t page_wr_i,
  output pdst_pkg::pdst_resp_t resp_o,
  output logic addr_err_o,
  output logic [15:0] err_addr_o,
  output logic err_write_o,
  output logic [9:0] rd_page_o,
  output logic [9:0] wr_page_o
);
  import pdst_pkg::*;

  logic [9:0] rd_page;
  logic [9:0] wr_page;
  logic [9:0] sel_page;
  pdst_resp_t map_d;
  logic trap_d;
  logic resp_valid_q;
  logic resp_write_q;
  logic resp_low_q;
  pdst_space_t resp_space_q;
  logic [23:0] resp_addr_q;
  logic addr_err_q;
  logic [15:0] err_addr_q;
  logic err_write_q;

  // The read page keeps all ten bits; the write page drops bit 9 so
  // it can never point into program space.
  pdst_page_reg #(
    .KEEP_MASK(`PDST_RD_PAGE_MASK)
  ) u_rd_page (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(page_wr_i.valid && !page_wr_i.sel_write),
    .data_i(page_wr_i.value),
    .q_o(rd_page)
  );

  pdst_page_reg #(
    .KEEP_MASK(`PDST_WR_PAGE_MASK)
  ) u_wr_page (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(page_wr_i.valid && page_wr_i.sel_write),
    .data_i(page_wr_i.value),
    .q_o(wr_page)
  );

  assign rd_page_o = rd_page;
  assign wr_page_o = wr_page;

  function automatic logic in_upper_window(
    input logic [15:0] addr
  );
    return addr[`PDST_BASE_MSB];
  endfunction

  function automatic logic in_low_region(
    input logic [15:0] addr
  );
    return addr <= `PDST_LOW_LAST;
  endfunction

  function automatic logic [9:0] page_for(
    input pdst_req_t req,
    input logic [9:0] rd,
    input logic [9:0] wr
  );
    // Writes always take the data-only write page
    return req.write ? wr : rd;
  endfunction

  function automatic logic page_is_zero(
    input logic [9:0] page
  );
    return page == `PDST_PAGE_ZERO;
  endfunction

  function automatic logic reads_program(
    input pdst_req_t req,
    input logic [9:0] page
  );
    return !req.write && (page >= `PDST_PSV_FIRST_PAGE);
  endfunction

  function automatic logic [23:0] eds_addr(
    input logic [9:0] page,
    input logic [15:0] addr
  );
    return {page[8:0], addr[14:0]};
  endfunction

  function automatic logic [23:0] psv_addr(
    input logic [9:0] page,
    input logic [15:0] addr
  );
    // Page bit 9 only selects program space and page bit 8 is dropped, so neither is part of the address
    return {1'b0, page[7:0], addr[14:0]};
  endfunction

  function automatic logic is_trap(
    input pdst_resp_t resp
  );
    return resp.valid && (resp.space == PDST_SP_NONE);
  endfunction

  function automatic pdst_resp_t map_access(
    input logic [9:0] page,
    input pdst_req_t req
  );
    pdst_resp_t r;
    r.valid = req.valid;
    r.write = req.write;
    r.low_region = in_low_region(req.addr);
    r.space = PDST_SP_BASE;
    r.addr = {8'h00, req.addr};
    if (in_upper_window(req.addr)) begin
      if (page_is_zero(page)) begin
        r.space = PDST_SP_NONE;
        r.addr = 24'h000000;
      end else if (reads_program(req, page)) begin
        r.space = PDST_SP_PSV;
        r.addr = psv_addr(page, req.addr);
      end else begin
        r.space = PDST_SP_EDS;
        r.addr = eds_addr(page, req.addr);
      end
    end
    return r;
  endfunction

  // Writes always use the data-only write page, so paging never
  // produces a program space write.
  assign sel_page = page_for(req_i, rd_page, wr_page);
  assign map_d = map_access(sel_page, req_i);
  assign trap_d = is_trap(map_d);

  // A page update in the same cycle as an access applies to later
  // accesses only; the access sees the old page.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_valid_q <= 1'b0;
    end else begin
      resp_valid_q <= map_d.valid;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_write_q <= 1'b0;
    end else begin
      resp_write_q <= map_d.write;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_low_q <= 1'b0;
    end else begin
      resp_low_q <= map_d.low_region;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_space_q <= PDST_SP_BASE;
    end else begin
      resp_space_q <= map_d.space;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_addr_q <= 24'h000000;
    end else begin
      resp_addr_q <= map_d.addr;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_err_q <= 1'b0;
    end else begin
      addr_err_q <= trap_d;
    end
  end

  // Last trapping access is held for the trap handler
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_addr_q <= 16'h0000;
    end else if (trap_d) begin
      err_addr_q <= req_i.addr;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_write_q <= 1'b0;
    end else if (trap_d) begin
      err_write_q <= req_i.write;
    end
  end

  assign resp_o = {resp_valid_q, resp_write_q, resp_low_q, resp_space_q,
                   resp_addr_q};
  assign addr_err_o = addr_err_q;
  assign err_addr_o = err_addr_q;
  assign err_write_o = err_write_q;

endmodule

// file: verification/pdst_properties.sv
`timescale 1ns/1ps
module pdst_chk import pdst_pkg::*; (
  input logic clk_i,
  input logic nrst_i,
  input pdst_req_t req_i,
  input pdst_page_wr_t page_wr_i,
  input pdst_resp_t resp_o,
  input logic addr_err_o,
  input logic [9:0] rd_page_o,
  input logic [9:0] wr_page_o
);
  logic [9:0] pg;
  logic up;
  assign pg = req_i.write ? wr_page_o : rd_page_o;
  assign up = req_i.valid && req_i.addr[15];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_low_base: assert property (req_i.valid && !req_i.addr[15] |=>
    resp_o.space == PDST_SP_BASE && resp_o.addr == {8'h00, $past(req_i.addr)}) else $error("low");
  a_eds_map: assert property (up && |pg && (req_i.write || !pg[9]) |=>
    resp_o.space == PDST_SP_EDS && resp_o.addr == {$past(pg[8:0]), $past(req_i.addr[14:0])})
    else $error("eds");
  a_psv_map: assert property (up && !req_i.write && pg[9] |=>
    resp_o.space == PDST_SP_PSV && resp_o.addr == {1'b0, $past(pg[7:0]), $past(req_i.addr[14:0])})
    else $error("psv");
  a_zero_trap: assert property (up |=> addr_err_o == ($past(pg) == 10'h000))
    else $error("trap");
  a_reset_one: assert property ($rose(nrst_i) |-> rd_page_o == 10'h001 && wr_page_o == 10'h001)
    else $error("reset");
  a_zero_kept: assert property (page_wr_i.valid && page_wr_i.value == 10'h000 |=>
    $stable(rd_page_o) && $stable(wr_page_o)) else $error("zero");
  a_no_psv_write: assert property (req_i.valid && req_i.write |=>
    resp_o.space != PDST_SP_PSV && resp_o.write && !wr_page_o[9]) else $error("wr");
  a_low_no_trap: assert property (req_i.valid && !req_i.addr[15] |=> !addr_err_o && resp_o.valid)
    else $error("low trap");
  a_low_flag: assert property (req_i.valid |=>
    resp_o.low_region == ($past(req_i.addr) <= 16'h2fff)) else $error("low flag");
  c_psv: cover property (resp_o.space == PDST_SP_PSV);
  c_eds: cover property (resp_o.space == PDST_SP_EDS);
  c_base: cover property (resp_o.valid && resp_o.space == PDST_SP_BASE);
endmodule

bind pdst_translator pdst_chk u_chk (.clk_i, .nrst_i, .req_i, .page_wr_i, .resp_o,
  .addr_err_o, .rd_page_o, .wr_page_o);

// file: verification/pdst_core_model.sv
`timescale 1ns/1ps
module pdst_core_model import pdst_pkg::*; (
  input logic clk_i,
  output pdst_req_t req_o,
  output pdst_page_wr_t pw_o
);
  initial req_o = '0;
  initial pw_o = '0;
  // Both set in one step so back-to-back calls never assign twice at once
  task go(pdst_req_t r, pdst_page_wr_t p);
    req_o = r;
    pw_o = p;
    @(posedge clk_i) #1;
  endtask
endmodule

// file: verification/pdst_translator_tb.sv
`timescale 1ns/1ps
module pdst_translator_tb;
  import pdst_pkg::*;
  logic clk_i = 0;
  logic nrst_i = 0;
  pdst_req_t req;
  pdst_page_wr_t pw;
  pdst_resp_t resp;
  logic [9:0] rp, wp;
  logic err, ew;
  logic [15:0] ea;
  int mismatches = 0;
  int tests_run = 0;
  always #12.5 clk_i = ~clk_i;
  pdst_core_model core (.clk_i, .req_o(req), .pw_o(pw));
  pdst_translator dut (.clk_i, .nrst_i, .req_i(req), .page_wr_i(pw), .resp_o(resp),
    .addr_err_o(err), .err_addr_o(ea), .err_write_o(ew), .rd_page_o(rp), .wr_page_o(wp));
  task chk(string n, logic [28:0] s, logic [28:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task acc(logic w, logic [15:0] a, logic [25:0] e);
    core.go({1'b1, w, a}, '0);
    chk("resp", {resp.space, resp.addr}, e);
    chk("flags", {resp.valid, resp.write, resp.low_region}, {1'b1, w, a <= 16'h2fff});
    chk("trap", {err, ea, ew}, '0);
  endtask
  task pg(logic s, logic [9:0] v);
    core.go('0, {1'b1, s, v});
  endtask
  task t_low;
    chk("pages", {rp, wp}, {10'h001, 10'h001});
    acc(0, 16'h0000, {PDST_SP_BASE, 24'h000000});
    acc(1, 16'h2fff, {PDST_SP_BASE, 24'h002fff});
    acc(0, 16'h3000, {PDST_SP_BASE, 24'h003000});
    $display("low done");
  endtask
  task t_page;
    acc(0, 16'h8000, {PDST_SP_EDS, 24'h008000});
    pg(0, 10'h002);
    acc(0, 16'h8000, {PDST_SP_EDS, 24'h010000});
    acc(1, 16'hffff, {PDST_SP_EDS, 24'h00ffff});
    pg(0, 10'h000);
    pg(1, 10'h200);
    chk("pages", {rp, wp}, {10'h002, 10'h001});
    acc(0, 16'h8000, {PDST_SP_EDS, 24'h010000});
    $display("page done");
  endtask
  task t_psv;
    pg(0, 10'h3ff);
    acc(0, 16'h8004, {PDST_SP_PSV, 24'h7f8004});
    acc(1, 16'h8004, {PDST_SP_EDS, 24'h008004});
    $display("psv done");
  endtask
  task t_reset;
    pg(1, 10'h0aa);
    nrst_i = 0;
    core.go('0, '0);
    chk("resp", resp, '0);
    chk("pages", {rp, wp}, {10'h001, 10'h001});
    nrst_i = 1;
    acc(1, 16'h8000, {PDST_SP_EDS, 24'h008000});
    acc(0, 16'h8000, {PDST_SP_EDS, 24'h008000});
    $display("reset done");
  endtask
  task print_verdict;
    $display("runs %0d bad %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    #1 nrst_i = 1;
    t_low;
    t_page;
    t_psv;
    t_reset;
    print_verdict;
  end
  initial begin
    #5us;
    mismatches++;
    print_verdict;
  end
endmodule
